/* File: include/ped_pkg.sv */
// Operation
// RL1 - Supply under/over voltage events, enables 7, 6
// RL2 - Over-temperature event bit 11, enable 3
// RL3 - Sleep mode change event, enable 2
// RL4 - Receive polarity change event, enable 1
// RL5 - One-hot violation event; bits 5-4 spare
// RL6 - PRBS lock loss sticky, write zero clears
// RL7 - Core normal power mode read-only bit
// RL8 - One-hot loopback select, bit 7 PCS digital
// RL9 - OAM acknowledge event, enable bit 7
// RL10 - OAM message pending clear event, enable 6
// RL11 - Power-on done event, enable resets to one
// RL12 - No frame detected event, enable 2
// RL13 - Wake request and low-power events
// RL14 - Strapped management address read-only, bits 4-0
// RL15 - Software cable test start, self clearing
// RL16 - Auto cable test on link down
// RL17 - Cable test done and fail, kept
// RL18 - Interrupt when enabled status bit set
// RL19 - Global interrupt enable and force bit
// RL20 - Interrupt polarity bit 3, default low
`default_nettype none
package ped_pkg;
   // Bus geometry: one register per 32-bit word, byte address = 4 * index
   localparam int unsigned PED_ADDR_W  = 8;
   localparam int unsigned PED_IDX_W   = 6;
   // Register indices
   localparam logic [5:0] PED_IDX_IRQ_CFG  = 6'h11;
   localparam logic [5:0] PED_IDX_SUPPLY   = 6'h13;
   localparam logic [5:0] PED_IDX_LOOPBACK = 6'h16;
   localparam logic [5:0] PED_IDX_LINKMGMT = 6'h18;
   localparam logic [5:0] PED_IDX_STRAP    = 6'h19;
   localparam logic [5:0] PED_IDX_CABLE    = 6'h1e;
   // Reset values
   localparam logic [15:0] PED_RST_IRQ_CFG  = 16'h000b;
   localparam logic [7:0]  PED_RST_SUP_EN   = 8'h00;
   localparam logic [7:0]  PED_RST_LNK_EN   = 8'h08;
   localparam logic [6:0]  PED_RST_LB_MODE  = 7'h00;
   // Writable bits of the interrupt configuration word (bit 7 read-only)
   localparam logic [15:0] PED_IRQ_CFG_WMASK = 16'hff7f;
   // Field positions in the interrupt configuration word
   localparam int unsigned PED_BIT_SELFCLR  = 11;
   localparam int unsigned PED_BIT_INT_POL  = 3;
   localparam int unsigned PED_BIT_FORCE    = 2;
   localparam int unsigned PED_BIT_INT_EN   = 1;
   // Status bytes sit in bits 15-8, enables in 7-0; bits 13-12 of status are reserved
   localparam logic [7:0]  PED_STATUS_MASK  = 8'hcf;
   // Loopback word fields
   localparam int unsigned PED_BIT_PRBS_LOSS = 10;
   localparam int unsigned PED_BIT_CORE_PWR  = 8;
   localparam int unsigned PED_BIT_DIG_LB    = 7;
   // Cable test word fields
   localparam int unsigned PED_BIT_CT_START  = 15;
   localparam int unsigned PED_BIT_CT_AUTO   = 14;
   localparam int unsigned PED_BIT_CT_DONE   = 1;
   localparam int unsigned PED_BIT_CT_FAIL   = 0;

   // Event pulses from the transceiver core, one cycle each
   typedef struct packed {
      logic under_volt;
      logic over_volt;
      logic over_temp;
      logic sleep_change;
      logic pol_change;
      logic not_one_hot;
      logic oam_ack;
      logic oam_msg_pending_clr;
      logic por_done;
      logic no_frame;
      logic wake_req;
      logic lps_event;
      logic prbs_lock_loss;
   } ped_events_t;

   // Whole register-bank state
   typedef struct packed {
      logic        waitreq;    // Avalon waitrequest
      logic [31:0] rdata;      // Avalon readdata
      logic [15:0] irq_cfg;    // Interrupt configuration word
      logic [7:0]  sup_st;     // Supply/thermal status byte
      logic [7:0]  sup_en;     // Supply/thermal enable byte
      logic [7:0]  lnk_st;     // Link management status byte
      logic [7:0]  lnk_en;     // Link management enable byte
      logic        prbs_loss;  // Sticky PRBS lock loss
      logic        dig_lb;     // PCS digital loopback enable
      logic [6:0]  lb_mode;    // One-hot loopback path
      logic        strap_ok;   // Strap already captured
      logic [4:0]  mgmt_addr;  // Captured strap address
      logic        ct_start;   // Cable test request pending
      logic        ct_auto;    // Auto-run on link down
      logic        ct_done;    // Cable test finished
      logic        ct_fail;    // Cable test failed
      logic        ct_pulse;   // Launch strobe to the cable tester
      logic        link_prev;  // Link level one cycle ago
      logic        irq_pin;    // Interrupt pin level after polarity
   } ped_state_t;
endpackage
`default_nettype wire

/* File: design/ped_regs.sv */
`default_nettype none
module ped_regs
   import ped_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // Avalon-MM slave
   input  wire logic [PED_ADDR_W-1:0] address_i,
   input  wire logic                  read_i,
   input  wire logic                  write_i,
   input  wire logic [31:0]           writedata_i,
   input  wire logic [3:0]            byteenable_i,
   output logic      [31:0]           readdata_o,
   output logic                       waitrequest_o,
   // Core side
   input  wire ped_events_t           events_i,
   input  wire logic                  core_normal_i,
   input  wire logic                  link_up_i,
   input  wire logic [4:0]            strapped_mgmt_address_i,
   input  wire logic                  cable_test_busy_i,
   input  wire logic                  cable_test_done_i,
   input  wire logic                  cable_test_fail_i,
   output logic                       cable_test_start_o,
   output logic [6:0]                 loopback_sel_o,
   output logic                       pcs_dig_loopback_o,
   output logic                       irq_pin_o
);

   ped_state_t s;        // Current state
   ped_state_t next_s;   // Next state

   logic [PED_IDX_W-1:0] idx;       // Word index of the access
   logic                 acc;       // Access completes this edge
   logic                 wr_acc;    // Write completes this edge
   logic                 rd_acc;    // Read completes this edge
   logic [15:0]          wmask;     // Byte lanes 0 and 1 as a bit mask
   logic [15:0]          wd;        // Low half of write data
   logic [7:0]           sup_evt;   // Supply/thermal events in status layout
   logic [7:0]           lnk_evt;   // Link management events in status layout
   logic [15:0]          rd_word;   // Value for a read set up this cycle
   logic                 irq_drive; // Interrupt asserted, before polarity

   assign idx = address_i[PED_ADDR_W-1:2];
   assign wd  = writedata_i[15:0];
   assign wmask = {{8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

   // Access finishes at the edge where waitrequest is already low
   assign acc    = ~s.waitreq & (read_i | write_i);
   assign wr_acc = ~s.waitreq & write_i;
   assign rd_acc = ~s.waitreq & read_i;

   // Pack the events into their status-bit positions
   always_comb begin
      sup_evt = {events_i.under_volt, events_i.over_volt, 2'b00,            // RL1
                 events_i.over_temp,                                         // RL2
                 events_i.sleep_change,                                      // RL3
                 events_i.pol_change,                                        // RL4
                 events_i.not_one_hot};                                      // RL5
      lnk_evt = {events_i.oam_ack,                                           // RL9
                 events_i.oam_msg_pending_clr, 2'b00,                        // RL10
                 events_i.por_done,                                          // RL11
                 events_i.no_frame,                                          // RL12
                 events_i.wake_req, events_i.lps_event};                     // RL13
   end

   // Read multiplexer; unmapped words read as zero
   always_comb begin
      rd_word = 16'h0000;
      case (idx)
         PED_IDX_IRQ_CFG: begin
            rd_word = s.irq_cfg;
         end
         PED_IDX_SUPPLY: begin
            rd_word = {s.sup_st & PED_STATUS_MASK, s.sup_en};
         end
         PED_IDX_LOOPBACK: begin
            rd_word[PED_BIT_PRBS_LOSS] = s.prbs_loss;                        // RL6
            rd_word[PED_BIT_CORE_PWR]  = core_normal_i;                      // RL7
            rd_word[PED_BIT_DIG_LB]    = s.dig_lb;
            rd_word[6:0]               = s.lb_mode;
         end
         PED_IDX_LINKMGMT: begin
            rd_word = {s.lnk_st & PED_STATUS_MASK, s.lnk_en};
         end
         PED_IDX_STRAP: begin
            rd_word[4:0] = s.mgmt_addr;                                      // RL14
         end
         PED_IDX_CABLE: begin
            rd_word[PED_BIT_CT_START] = s.ct_start;
            rd_word[PED_BIT_CT_AUTO]  = s.ct_auto;
            rd_word[PED_BIT_CT_DONE]  = s.ct_done;                           // RL17
            rd_word[PED_BIT_CT_FAIL]  = s.ct_fail;
         end
         default: begin
            rd_word = 16'h0000;
         end
      endcase
   end

   // Interrupt request before polarity; force overrides the global enable
   always_comb begin
      irq_drive = s.irq_cfg[PED_BIT_FORCE] |                                 // RL19
                  (s.irq_cfg[PED_BIT_INT_EN] &                               // RL19
                   (|(s.sup_st & PED_STATUS_MASK & s.sup_en) |               // RL18
                    |(s.lnk_st & PED_STATUS_MASK & s.lnk_en)));              // RL18
   end

   // Next-state logic for the whole bank
   always_comb begin
      next_s = s;

      // Bus handshake: one wait cycle, then a single cycle with waitrequest low
      if (!s.waitreq) begin
         next_s.waitreq = 1'b1;
      end else if (read_i || write_i) begin
         next_s.waitreq = 1'b0;
         next_s.rdata   = {16'h0000, rd_word};
      end

      // Self-clearing reserved bit of the configuration word
      next_s.irq_cfg[PED_BIT_SELFCLR] = 1'b0;

      // Register writes, gated by byte lanes
      if (wr_acc) begin
         case (idx)
            PED_IDX_IRQ_CFG: begin
               next_s.irq_cfg = (s.irq_cfg & ~(wmask & PED_IRQ_CFG_WMASK)) |
                                (wd & wmask & PED_IRQ_CFG_WMASK);            // RL20
            end
            PED_IDX_SUPPLY: begin
               if (byteenable_i[0]) begin
                  next_s.sup_en = wd[7:0];                                   // RL1
               end
            end
            PED_IDX_LOOPBACK: begin
               if (byteenable_i[1] && !wd[PED_BIT_PRBS_LOSS]) begin
                  next_s.prbs_loss = 1'b0;                                   // RL6
               end
               if (byteenable_i[0]) begin
                  next_s.dig_lb  = wd[PED_BIT_DIG_LB];                       // RL8
                  next_s.lb_mode = wd[6:0];                                  // RL8
               end
            end
            PED_IDX_LINKMGMT: begin
               if (byteenable_i[0]) begin
                  next_s.lnk_en = wd[7:0];                                   // RL11
               end
            end
            PED_IDX_CABLE: begin
               if (byteenable_i[1]) begin
                  next_s.ct_auto = wd[PED_BIT_CT_AUTO];                      // RL16
                  if (wd[PED_BIT_CT_START]) begin
                     next_s.ct_start = 1'b1;                                 // RL15
                  end
               end
            end
            default: begin
               next_s.irq_cfg[PED_BIT_SELFCLR] = 1'b0;
            end
         endcase
      end

      // Reading an event word clears only the bits that it reported, so an event
      // landing between data capture and the end of the read is not lost
      if (rd_acc && idx == PED_IDX_SUPPLY) begin
         next_s.sup_st = s.sup_st & ~s.rdata[15:8];
      end
      if (rd_acc && idx == PED_IDX_LINKMGMT) begin
         next_s.lnk_st = s.lnk_st & ~s.rdata[15:8];
      end
      next_s.sup_st = next_s.sup_st | sup_evt;                               // RL1
      next_s.lnk_st = next_s.lnk_st | lnk_evt;                               // RL9
      if (events_i.prbs_lock_loss) begin
         next_s.prbs_loss = 1'b1;                                            // RL6
      end

      // Strap address caught once, on the first edge after reset release
      if (!s.strap_ok) begin
         next_s.strap_ok  = 1'b1;
         next_s.mgmt_addr = strapped_mgmt_address_i;                         // RL14
      end

      // Auto-run: a falling link level requests a measurement
      next_s.link_prev = link_up_i;
      if (s.ct_auto && s.link_prev && !link_up_i) begin
         next_s.ct_start = 1'b1;                                             // RL16
      end

      // Launch when the tester is idle; the request bit clears as it is taken
      next_s.ct_pulse = 1'b0;
      if (s.ct_start && !cable_test_busy_i && !s.ct_pulse) begin
         next_s.ct_pulse = 1'b1;
         next_s.ct_start = 1'b0;                                             // RL15
         next_s.ct_done  = 1'b0;                                             // RL17
         next_s.ct_fail  = 1'b0;                                             // RL17
      end else if (cable_test_done_i) begin
         next_s.ct_done = 1'b1;                                              // RL17
         next_s.ct_fail = cable_test_fail_i;                                 // RL17
      end

      // Pin level: polarity bit high means active low
      next_s.irq_pin = s.irq_cfg[PED_BIT_INT_POL] ? ~irq_drive : irq_drive;  // RL20
   end

   // State register; the interrupt pin idles high because polarity resets to low-active
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s           <= '0;
         s.waitreq   <= 1'b1;
         s.irq_cfg   <= PED_RST_IRQ_CFG;                                     // RL19
         s.sup_en    <= PED_RST_SUP_EN;
         s.lnk_en    <= PED_RST_LNK_EN;                                      // RL11
         s.lb_mode   <= PED_RST_LB_MODE;
         s.irq_pin   <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from state flops
   assign readdata_o         = s.rdata;
   assign waitrequest_o      = s.waitreq;
   assign cable_test_start_o = s.ct_pulse;
   assign loopback_sel_o     = s.lb_mode;
   assign pcs_dig_loopback_o = s.dig_lb;
   assign irq_pin_o          = s.irq_pin;

   // Unused upper write data and lanes are ignored by design
   logic unused_ok;
   assign unused_ok = &{1'b0, writedata_i[31:16], byteenable_i[3:2], acc};
endmodule
`default_nettype wire

/* File: bench/ped_chk.sv */
`default_nettype none
// Watches the register bus and the loopback and cable-test outputs
module ped_chk
   import ped_pkg::*;
(
   input wire logic                  clk_i,
   input wire logic                  rst_n_i,
   input wire logic [PED_ADDR_W-1:0] address_i,
   input wire logic                  read_i,
   input wire logic                  write_i,
   input wire logic [31:0]           writedata_i,
   input wire logic [3:0]            byteenable_i,
   input wire logic [31:0]           readdata_o,
   input wire logic                  waitrequest_o,
   input wire logic                  cable_test_busy_i,
   input wire logic                  cable_test_start_o,
   input wire logic [6:0]            loopback_sel_o,
   input wire logic                  pcs_dig_loopback_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Completed low-lane write to the loopback word
   wire logic lb_wr = write_i && !waitrequest_o && address_i == 8'h58 && byteenable_i[0];
   // Completed start request to the cable test word
   wire logic ct_wr = write_i && !waitrequest_o && address_i == 8'h78 && byteenable_i[1]
                      && writedata_i[15];
   // Completed read of a given word
   wire logic rd_19 = read_i && !waitrequest_o && address_i == 8'h64;
   wire logic rd_1e = read_i && !waitrequest_o && address_i == 8'h78;
   a_wait_taken: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("bus request not answered after one wait cycle");
   a_lb_on_write: assert property ($changed(loopback_sel_o) |-> $past(lb_wr))
      else $error("loopback select changed without a write");
   a_lb_value: assert property (lb_wr |=> loopback_sel_o == $past(writedata_i[6:0]))
      else $error("loopback select differs from written code");
   a_dig_lb_value: assert property (lb_wr |=> pcs_dig_loopback_o == $past(writedata_i[7]))
      else $error("digital loopback differs from written bit");
   a_start_single: assert property (cable_test_start_o |=> !cable_test_start_o)
      else $error("cable test start longer than one cycle");
   a_start_idle: assert property (cable_test_start_o |-> !$past(cable_test_busy_i))
      else $error("cable test launched while tester busy");
   // Start request taken while the tester is idle, and tester still idle one cycle on
   wire logic ct_go    = ct_wr && !cable_test_busy_i;
   wire logic tst_idle = !cable_test_busy_i;
   a_start_after_wr: assert property (ct_go ##1 tst_idle |=> cable_test_start_o)
      else $error("cable test start missing after request");
   a_strap_upper: assert property (rd_19 |-> readdata_o[15:5] == 11'h000)
      else $error("strap word upper bits not zero");
   a_ct_reserved: assert property (rd_1e |-> readdata_o[13:2] == 12'h000)
      else $error("cable test reserved bits not zero");
   c_lb_wr: cover property (lb_wr);
   c_start: cover property (cable_test_start_o);
   c_strap_rd: cover property (rd_19);
endmodule
bind ped_regs ped_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i),
   .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
   .cable_test_busy_i(cable_test_busy_i), .cable_test_start_o(cable_test_start_o),
   .loopback_sel_o(loopback_sel_o), .pcs_dig_loopback_o(pcs_dig_loopback_o));
`default_nettype wire

/* File: bench/ped_tester.sv */
`default_nettype none
// Cable tester stand-in: busy for seven cycles after a launch, then one done pulse
module ped_tester (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic start_i,
   input  wire logic fail_mode_i,
   output logic      busy_o,
   output logic      done_o,
   output logic      fail_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt; // Cycles left in the measurement
   // Count down the measurement and pulse done at the end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt    <= 3'h0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= busy_o && cnt == 3'h1;
         if (start_i) begin
            busy_o <= 1'b1;
            cnt    <= 3'h7;
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
               busy_o <= 1'b0;
            end
         end
      end
   end
   // Outside the done pulse the fail line shows the wrong level on purpose
   assign fail_o = done_o ? fail_mode_i : !fail_mode_i;
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ped_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [7:0]  address_i = 8'h00;
   logic        read_i = 1'b0;
   logic        write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic [3:0]  byteenable_i = 4'h3;  // Only lanes 0 and 1 carry bits
   ped_events_t events_i = '0;
   logic        core_normal = 1'b0;
   logic        link_up = 1'b0;
   logic [4:0]  strap = 5'h15;
   logic        fail_mode = 1'b0;
   logic [31:0] readdata_o;
   logic        waitrequest_o, busy, done, fail, start, dig_lb, irq;
   logic [6:0]  lb_sel;
   logic [15:0] rd;                   // Last read data
   int          n_errors = 0;
   int          checks_done = 0;
   always #5 clk_i = ~clk_i;
   ped_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .events_i(events_i),
      .core_normal_i(core_normal), .link_up_i(link_up), .strapped_mgmt_address_i(strap),
      .cable_test_busy_i(busy), .cable_test_done_i(done), .cable_test_fail_i(fail),
      .cable_test_start_o(start), .loopback_sel_o(lb_sel), .pcs_dig_loopback_o(dig_lb),
      .irq_pin_o(irq));
   ped_tester u_tst (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
      .fail_mode_i(fail_mode), .busy_o(busy), .done_o(done), .fail_o(fail));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One bus access; the request stands until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
      int n;
      @(posedge clk_i);
      read_i      <= !wr;
      write_i     <= wr;
      address_i   <= a;
      writedata_i <= {16'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20) chk("waitrequest", 16'h0, 16'h1);
      rd = readdata_o[15:0];
      read_i  <= 1'b0;
      write_i <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      bus(1'b0, a, 16'h0);
      chk($sformatf("reg %h", a), exp, rd);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // One-cycle event pulse, then wait until the pin has had time to follow
   task automatic pulse(input logic [12:0] v);
      @(posedge clk_i);
      events_i <= v;
      @(posedge clk_i);
      events_i <= '0;
      settle(2);
   endtask
   task automatic wait_hi(input logic on_done);
      int n;
      n = 0;
      while ((on_done ? done : start) !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) chk("tester handshake", 16'h1, 16'h0);
   endtask
   task automatic t_reset;
      strap <= 5'h0a;  // Late strap change must not be seen
      rdchk(8'h4c, 16'h0000);
      rdchk(8'h60, 16'h0008);
      rdchk(8'h78, 16'h0000);
      rdchk(8'h44, 16'h000b);
      rdchk(8'h00, 16'h0000);
      rdchk(8'h64, 16'h0015);
      chk("irq idle", 16'h1, {15'h0, irq});
      pulse(13'h0010);
      chk("irq por", 16'h0, {15'h0, irq});
      rdchk(8'h60, 16'h0808);
   endtask
   // Each of the twelve status-word events alone with only its own enable set, then cleared by a read
   task automatic t_events;
      int          pos_tab[6] = '{15, 14, 11, 10, 9, 8};
      logic [15:0] bitv;
      logic [7:0]  a;
      for (int k = 0; k < 12; k++) begin
         bitv = 16'h1 << pos_tab[k % 6];
         a    = (k < 6) ? 8'h4c : 8'h60;
         bus(1'b1, a, bitv >> 8);
         pulse(13'h1 << (12 - k));
         chk("irq event", 16'h0, {15'h0, irq});
         rdchk(a, bitv | (bitv >> 8));
         settle(1);
         chk("irq cleared", 16'h1, {15'h0, irq});
         rdchk(a, bitv >> 8);
      end
      bus(1'b1, 8'h4c, 16'h0030);
      pulse(13'h0400);
      chk("irq masked", 16'h1, {15'h0, irq});
      rdchk(8'h4c, 16'h0830);
   endtask
   // Force and polarity combinations, then restore the reset word
   task automatic t_irq;
      logic [15:0] cfg[3] = '{16'h000e, 16'h0006, 16'h0002};
      logic        exp[3] = '{1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 8'h44, cfg[i]);
         settle(1);
         chk("irq cfg", {15'h0, exp[i]}, {15'h0, irq});
      end
      bus(1'b1, 8'h44, 16'h088b);
      rdchk(8'h44, 16'h000b);
   endtask
   task automatic t_loop;
      logic [6:0] code[5] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10};
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, 8'h58, {8'h00, i[0], code[i]});
         #1;
         chk("lb sel", {9'h0, code[i]}, {9'h0, lb_sel});
         chk("dig lb", {15'h0, i[0]}, {15'h0, dig_lb});
         rdchk(8'h58, {8'h00, i[0], code[i]});
      end
      core_normal <= 1'b1;
      pulse(13'h0001);
      rdchk(8'h58, 16'h0510);
      rdchk(8'h58, 16'h0510);
      bus(1'b1, 8'h58, 16'h0410);
      rdchk(8'h58, 16'h0510);
      bus(1'b1, 8'h58, 16'h0010);
      rdchk(8'h58, 16'h0110);
      core_normal <= 1'b0;
   endtask
   task automatic t_cable;
      bus(1'b1, 8'h78, 16'h8000);
      wait_hi(1'b0);
      wait_hi(1'b1);
      settle(1);
      rdchk(8'h78, 16'h0002);
      fail_mode <= 1'b1;
      bus(1'b1, 8'h78, 16'h4000);
      link_up <= 1'b1;
      repeat (2) @(posedge clk_i);
      link_up <= 1'b0;
      wait_hi(1'b0);
      rdchk(8'h78, 16'h4000);
      wait_hi(1'b1);
      settle(1);
      rdchk(8'h78, 16'h4003);
   endtask
   task automatic report_and_stop;
      if (n_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      t_reset();
      t_events();
      t_irq();
      t_loop();
      t_cable();
      report_and_stop();
   end
   // Watchdog: the run needs a few hundred cycles
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
